// ==== src/lmcfg_bank.sv ====
// Configuration and command register bank of the LED matrix driver, reached over I2C
`timescale 1ns/1ps
module lmcfg_bank #(
   parameter logic [1:0] CHIP_SEL = 2'h0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Device control
   output logic chip_enable,
   output logic range_51ma,
   output logic [3:0] scan_topology,
   output logic [lmcfg_pkg::SHORT_W-1:0] short_threshold,
   output logic [8*lmcfg_pkg::CFG_COUNT-1:0] active_cfg,
   output logic cfg_apply,
   output logic cfg_error,
   // Per-dot settings
   output logic [lmcfg_pkg::LED_COUNT-1:0] led_enable,
   output logic [8*lmcfg_pkg::DOT_COUNT-1:0] dot_current,
   output logic [8*lmcfg_pkg::DOT_COUNT-1:0] dot_pwm
);
   localparam int NC = lmcfg_pkg::CFG_COUNT;
   localparam int ND = lmcfg_pkg::DOT_COUNT;

   logic wr_stb;
   logic [9:0] wr_addr, rd_addr;
   logic [7:0] wr_data, rd_data;
   logic en_reg, en_next;
   logic [7:0] stage_reg [NC], stage_next [NC];
   logic [7:0] act_reg [NC], act_next [NC];
   logic [3:0] lhi_reg, lhi_next;
   logic [7:0] llo_reg, llo_next;
   logic [7:0] dc_reg [ND], dc_next [ND];
   logic [7:0] pwm_reg [ND], pwm_next [ND];
   logic err_reg, err_next;
   logic apply_reg, apply_next;
   logic hit_cfg, hit_dc, hit_pwm, apply_now;
   logic [9:0] cfg_idx;

   lmcfg_i2c_target #(
      .CHIP_SEL(CHIP_SEL)
   ) u_target (
      .mclk(mclk),
      .rstn(rstn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Address decode shared by writes
   assign cfg_idx = wr_addr - lmcfg_pkg::OFS_CFG_FIRST;
   assign hit_cfg = wr_addr >= lmcfg_pkg::OFS_CFG_FIRST && wr_addr <= lmcfg_pkg::OFS_CFG_LAST;
   assign hit_dc = wr_addr[9:4] == lmcfg_pkg::OFS_DC_BASE[9:4];
   assign hit_pwm = wr_addr[9:4] == lmcfg_pkg::OFS_PWM_BASE[9:4];
   // Only the exact command code applies; anything else is dropped
   assign apply_now = wr_stb && wr_addr == lmcfg_pkg::OFS_CMD &&
                      wr_data == lmcfg_pkg::CMD_APPLY;

   // Register writes; staged config never touches the active copy directly
   always_comb begin
      en_next = en_reg;
      lhi_next = lhi_reg;
      llo_next = llo_reg;
      apply_next = apply_now;
      err_next = err_reg;
      for (int i = 0; i < NC; i++) begin
         stage_next[i] = stage_reg[i];
         act_next[i] = act_reg[i];
      end
      for (int i = 0; i < ND; i++) begin
         dc_next[i] = dc_reg[i];
         pwm_next[i] = pwm_reg[i];
      end
      if (wr_stb) begin
         if (wr_addr == lmcfg_pkg::OFS_ENABLE) begin
            en_next = wr_data[lmcfg_pkg::ENABLE_BIT];
         end
         if (hit_cfg) begin
            stage_next[cfg_idx[3:0]] = wr_data;
         end
         if (wr_addr == lmcfg_pkg::OFS_LEDEN_HI) begin
            lhi_next = wr_data[7:lmcfg_pkg::LEDEN_HI_LSB];
         end
         if (wr_addr == lmcfg_pkg::OFS_LEDEN_LO) begin
            llo_next = wr_data;
         end
         if (hit_dc) begin
            dc_next[wr_addr[3:0]] = wr_data;
         end
         if (hit_pwm) begin
            pwm_next[wr_addr[3:0]] = wr_data;
         end
      end
      // Apply copies the whole staged set at once and judges it
      if (apply_now) begin
         for (int i = 0; i < NC; i++) begin
            act_next[i] = stage_reg[i];
         end
         err_next = stage_reg[lmcfg_pkg::CFG_IDX_TOPO][7:lmcfg_pkg::TOPO_LSB] >
                    lmcfg_pkg::TOPO_MAX;
      end
   end

   // Bank registers; config starts from working defaults
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         en_reg <= 1'b0;
         lhi_reg <= 4'h0;
         llo_reg <= lmcfg_pkg::BYTE_RESET;
         err_reg <= 1'b0;
         apply_reg <= 1'b0;
         for (int i = 0; i < NC; i++) begin
            stage_reg[i] <= lmcfg_pkg::CFG_RESET[8*i +: 8];
            act_reg[i] <= lmcfg_pkg::CFG_RESET[8*i +: 8];
         end
         for (int i = 0; i < ND; i++) begin
            dc_reg[i] <= lmcfg_pkg::BYTE_RESET;
            pwm_reg[i] <= lmcfg_pkg::BYTE_RESET;
         end
      end else begin
         en_reg <= en_next;
         lhi_reg <= lhi_next;
         llo_reg <= llo_next;
         err_reg <= err_next;
         apply_reg <= apply_next;
         for (int i = 0; i < NC; i++) begin
            stage_reg[i] <= stage_next[i];
            act_reg[i] <= act_next[i];
         end
         for (int i = 0; i < ND; i++) begin
            dc_reg[i] <= dc_next[i];
            pwm_reg[i] <= pwm_next[i];
         end
      end
   end

   // Read mux; reads have no side effects, unmapped and command read as zero
   always_comb begin
      rd_data = 8'h00;
      if (rd_addr == lmcfg_pkg::OFS_ENABLE) begin
         rd_data[lmcfg_pkg::ENABLE_BIT] = en_reg;
      end else if (rd_addr >= lmcfg_pkg::OFS_CFG_FIRST && rd_addr <= lmcfg_pkg::OFS_CFG_LAST) begin
         rd_data = stage_reg[4'(rd_addr - lmcfg_pkg::OFS_CFG_FIRST)];
      end else if (rd_addr == lmcfg_pkg::OFS_LEDEN_HI) begin
         rd_data = {lhi_reg, 4'h0};
      end else if (rd_addr == lmcfg_pkg::OFS_LEDEN_LO) begin
         rd_data = llo_reg;
      end else if (rd_addr[9:4] == lmcfg_pkg::OFS_DC_BASE[9:4]) begin
         rd_data = dc_reg[rd_addr[3:0]];
      end else if (rd_addr[9:4] == lmcfg_pkg::OFS_PWM_BASE[9:4]) begin
         rd_data = pwm_reg[rd_addr[3:0]];
      end else if (rd_addr == lmcfg_pkg::OFS_STATUS) begin
         rd_data[lmcfg_pkg::ERR_BIT] = err_reg;
      end
   end

   // Device control outputs; range, topology and short threshold from the active copy
   assign chip_enable = en_reg;
   assign range_51ma = act_reg[lmcfg_pkg::CFG_IDX_RANGE][lmcfg_pkg::RANGE_BIT];
   assign scan_topology = act_reg[lmcfg_pkg::CFG_IDX_TOPO][7:lmcfg_pkg::TOPO_LSB];
   assign short_threshold = act_reg[lmcfg_pkg::CFG_IDX_SHORT][lmcfg_pkg::SHORT_LSB +:
                            lmcfg_pkg::SHORT_W];
   assign cfg_apply = apply_reg;
   assign cfg_error = err_reg;
   assign led_enable = {lhi_reg, llo_reg};

   // Flatten the arrays onto the output buses
   genvar g;
   generate
      for (g = 0; g < ND; g++) begin : g_dot
         assign dot_current[8*g +: 8] = dc_reg[g];
         assign dot_pwm[8*g +: 8] = pwm_reg[g];
         if (g < NC) begin : g_cfg
            assign active_cfg[8*g +: 8] = act_reg[g];
         end
      end
   endgenerate

   // Enable write lands in the next cycle
   enable_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_stb && wr_addr == lmcfg_pkg::OFS_ENABLE |=> chip_enable == $past(wr_data[0]))
      else $error("enable bit did not follow the write");

   // Range only changes on apply and takes the staged bit
   range_apply_a: assert property (@(posedge mclk) disable iff (!rstn)
      apply_now |=> range_51ma == $past(stage_reg[lmcfg_pkg::CFG_IDX_RANGE][0]))
      else $error("range did not take the staged value");

   // Topology nibble reaches the output one cycle after apply
   topo_apply_a: assert property (@(posedge mclk) disable iff (!rstn)
      apply_now && stage_reg[lmcfg_pkg::CFG_IDX_TOPO] == 8'h40 |=> scan_topology == 4'h4)
      else $error("topology 40h did not select four scans");

   // Apply raises the marker and copies staged to active together
   apply_copy_a: assert property (@(posedge mclk) disable iff (!rstn)
      apply_now |=> cfg_apply && active_cfg[15:8] == $past(stage_reg[1]))
      else $error("apply did not copy the staged set");

   // Error flag matches the topology check after each apply
   cfg_error_a: assert property (@(posedge mclk) disable iff (!rstn)
      cfg_apply |-> cfg_error == (scan_topology > lmcfg_pkg::TOPO_MAX))
      else $error("error flag disagrees with applied topology");

   // Upper enable register drives the top four LED bits
   led_upper_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_stb && wr_addr == lmcfg_pkg::OFS_LEDEN_HI |=> led_enable[11:8] == $past(wr_data[7:4]))
      else $error("upper LED enables not updated");

   // Current code is stored for its dot
   dot_current_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_stb && hit_dc |=> dc_reg[$past(wr_addr[3:0])] == $past(wr_data))
      else $error("dot current code lost");

   // Duty code is stored for its dot
   dot_pwm_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_stb && hit_pwm |=> pwm_reg[$past(wr_addr[3:0])] == $past(wr_data))
      else $error("dot duty code lost");

   // Defaults hold right after reset release
   cfg_default_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> active_cfg == lmcfg_pkg::CFG_RESET)
      else $error("active config not at defaults after reset");

   // Active config is frozen between apply commands
   staged_only_a: assert property (@(posedge mclk) disable iff (!rstn)
      !apply_now |=> $stable(active_cfg))
      else $error("active config moved without apply");

   // Wrong command codes apply nothing
   bad_cmd_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_stb && wr_addr == lmcfg_pkg::OFS_CMD && wr_data != lmcfg_pkg::CMD_APPLY |=> !cfg_apply)
      else $error("non-command value applied config");
endmodule

// ==== src/lmcfg_pkg.sv ====
// Package: register map, field layout, reset values and I2C address codes of the config bank
// How it works
// - Writing 01h to register 000h sets the enable bit and takes the device out of standby.
// - Range field value 1h in register 001h selects the 51 mA peak current range.
// - Upper nibble of register 002h holds the drive topology; 4h selects four-line scan drive.
// - Writing command code 55h to register 010h applies the staged configuration.
// - Register 300h reports whether the last applied configuration was invalid.
// - Twelve LED enable bits live in 020h[7:4] and 021h, so F0h and FFh enable all twelve.
// - Registers 030h to 03Fh hold per-dot current codes scaling the range, FFh is full scale.
// - Registers 040h to 04Fh hold per-dot PWM duty, FFh means always on in its scan slot.
// - All configuration fields start from working defaults until the host reprograms them.
// - Writes to configuration registers are staged and only take effect on the apply command.
// - Byte one holds chip address, register bits 9:8 and R/W; byte two holds the low address.
package lmcfg_pkg;
   // Register offsets (10-bit register address)
   localparam logic [9:0] OFS_ENABLE = 10'h000;
   localparam logic [9:0] OFS_CFG_FIRST = 10'h001;
   localparam logic [9:0] OFS_CFG_LAST = 10'h00d;
   localparam logic [9:0] OFS_CMD = 10'h010;
   localparam logic [9:0] OFS_LEDEN_HI = 10'h020;
   localparam logic [9:0] OFS_LEDEN_LO = 10'h021;
   localparam logic [9:0] OFS_DC_BASE = 10'h030;
   localparam logic [9:0] OFS_PWM_BASE = 10'h040;
   localparam logic [9:0] OFS_STATUS = 10'h300;
   // Array sizes
   localparam int CFG_COUNT = 13;
   localparam int DOT_COUNT = 16;
   localparam int LED_COUNT = 12;
   // Field positions inside the staged config array and the enable, LED enable and status registers
   localparam int CFG_IDX_RANGE = 0;
   localparam int CFG_IDX_TOPO = 1;
   localparam int CFG_IDX_SHORT = 12;
   localparam int ENABLE_BIT = 0;
   localparam int RANGE_BIT = 0;
   localparam int TOPO_LSB = 4;
   localparam int SHORT_LSB = 0;
   localparam int SHORT_W = 2;
   localparam int LEDEN_HI_LSB = 4;
   localparam int ERR_BIT = 0;
   // Command and validity
   localparam logic [7:0] CMD_APPLY = 8'h55;
   localparam logic [3:0] TOPO_MAX = 4'h7;
   // Working defaults of config registers 001h..00Dh, index 0 in the low byte
   localparam logic [8*CFG_COUNT-1:0] CFG_RESET = 104'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // I2C address byte codes
   localparam logic [2:0] CHIP_FAMILY = 3'h5;
   localparam logic [4:0] BCAST_ID = 5'h1b;
endpackage

// ==== src/lmcfg_i2c_target.sv ====
// I2C target engine: framing, address phase, auto-increment register access
`timescale 1ns/1ps
module lmcfg_i2c_target #(
   parameter logic [1:0] CHIP_SEL = 2'h0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // I2C pins, sda is open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Register access
   output logic wr_stb,
   output logic [9:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [9:0] rd_addr,
   input wire logic [7:0] rd_data
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEV = 6'h02,
      ST_ADR = 6'h04,
      ST_WR = 6'h08,
      ST_RD = 6'h10,
      ST_SKIP = 6'h20
   } lmcfg_state_type;

   lmcfg_state_type state_reg, state_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [9:0] addr_reg, addr_next;
   logic rw_reg, rw_next;
   logic oe_reg, oe_next;
   logic stb_reg, stb_next;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_seen, stop_seen, dev_hit;

   // Bus conditions from the previous pin sample
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
   // Own address or broadcast; broadcast is write only
   assign dev_hit = (sh_reg[7:3] == {lmcfg_pkg::CHIP_FAMILY, CHIP_SEL}) ||
                    (sh_reg[7:3] == lmcfg_pkg::BCAST_ID && !sh_reg[0]);

   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign wr_stb = stb_reg;
   assign wr_addr = addr_reg;
   assign wr_data = sh_reg;
   assign rd_addr = addr_reg;

   // Protocol sequencer; start and stop override every state
   always_comb begin
      state_next = state_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      addr_next = addr_reg;
      rw_next = rw_reg;
      oe_next = oe_reg;
      stb_next = 1'b0;
      if (start_seen) begin
         state_next = ST_DEV;
         bit_next = 4'h0;
         oe_next = 1'b0;
      end else if (stop_seen) begin
         state_next = ST_IDLE;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            ST_DEV, ST_ADR, ST_WR: begin
               if (scl_rise && bit_reg < 4'h8) begin
                  sh_next = {sh_reg[6:0], sda_in};
                  bit_next = bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == 4'h8) begin
                  bit_next = 4'h9;
                  oe_next = 1'b1;
                  if (state_reg == ST_DEV) begin
                     if (dev_hit) begin
                        addr_next[9:8] = sh_reg[2:1];
                        rw_next = sh_reg[0];
                     end else begin
                        state_next = ST_SKIP;
                        oe_next = 1'b0;
                     end
                  end else if (state_reg == ST_ADR) begin
                     addr_next[7:0] = sh_reg;
                  end else begin
                     stb_next = 1'b1;
                  end
               end else if (scl_fall && bit_reg == 4'h9) begin
                  bit_next = 4'h0;
                  oe_next = 1'b0;
                  if (state_reg == ST_WR) begin
                     addr_next = addr_reg + 10'h001;
                  end else if (state_reg == ST_ADR) begin
                     state_next = ST_WR;
                  end else if (rw_reg) begin
                     state_next = ST_RD;
                     sh_next = rd_data;
                     oe_next = ~rd_data[7];
                     addr_next = addr_reg + 10'h001;
                  end else begin
                     state_next = ST_ADR;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall && bit_reg < 4'h7) begin
                  sh_next = {sh_reg[6:0], 1'b0};
                  oe_next = ~sh_reg[6];
                  bit_next = bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == 4'h7) begin
                  oe_next = 1'b0;
                  bit_next = 4'h8;
               end else if (scl_rise && bit_reg == 4'h8 && sda_in) begin
                  state_next = ST_SKIP; // Controller nack ends the read
               end else if (scl_fall && bit_reg == 4'h8) begin
                  bit_next = 4'h0;
                  sh_next = rd_data;
                  oe_next = ~rd_data[7];
                  addr_next = addr_reg + 10'h001;
               end
            end
            ST_IDLE, ST_SKIP: begin
               oe_next = 1'b0;
            end
            default: begin
               state_next = ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   // Sequencer and pin sample registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         addr_reg <= 10'h000;
         rw_reg <= 1'b0;
         oe_reg <= 1'b0;
         stb_reg <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         addr_reg <= addr_next;
         rw_reg <= rw_next;
         oe_reg <= oe_next;
         stb_reg <= stb_next;
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end
endmodule

// ==== bench/lmcfg_host.sv ====
// Host controller model: bit-level I2C controller facing the config bank
`timescale 1ns/1ps
module lmcfg_host (
   // Clock
   mclk,
   // Bus lines, sda is open drain with a pull-up outside
   sda_line,
   scl,
   sda_pull
);
   input wire logic mclk;
   input wire logic sda_line;
   output logic scl;
   output logic sda_pull;
   localparam int PHASE = 4;
   // Idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // All pin changes land on falling edges, away from the sampling edge
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start();
      sda_pull = 1'b0;
      tick(PHASE);
      scl = 1'b1;
      tick(PHASE);
      sda_pull = 1'b1;
      tick(PHASE);
      scl = 1'b0;
      tick(1);
   endtask
   // Stop: data rises while the clock is high
   task automatic stop();
      sda_pull = 1'b1;
      tick(PHASE);
      scl = 1'b1;
      tick(PHASE);
      sda_pull = 1'b0;
      tick(PHASE);
   endtask
   // One bit; data is held a cycle past the clock fall to cover the hold time
   task automatic clk_bit(input logic b, output logic r);
      sda_pull = ~b;
      tick(PHASE);
      scl = 1'b1;
      tick(2);
      r = sda_line;
      tick(2);
      scl = 1'b0;
      tick(1);
   endtask
   // Byte MSB first plus the ninth bit; send 8'hff to let the device talk
   task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                       output logic r9);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], rx[i]);
      end
      clk_bit(b9, r9);
   endtask
endmodule

// ==== bench/lmcfg_bank_tb_top.sv ====
// Testbench for the config bank: register traffic over I2C with expected values
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module lmcfg_bank_tb_top;
   localparam logic [1:0] SEL = 2'h2;
   localparam logic [4:0] OWN_ID = {lmcfg_pkg::CHIP_FAMILY, SEL};
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic scl;
   logic sda_pull;
   logic sda_out;
   logic sda_oe;
   logic chip_enable;
   logic range_51ma;
   logic [3:0] scan_topology;
   logic [lmcfg_pkg::SHORT_W-1:0] short_threshold;
   logic [8*lmcfg_pkg::CFG_COUNT-1:0] active_cfg;
   logic [8*lmcfg_pkg::CFG_COUNT-1:0] exp_cfg;
   logic cfg_apply;
   logic cfg_error;
   logic [lmcfg_pkg::LED_COUNT-1:0] led_enable;
   logic [8*lmcfg_pkg::DOT_COUNT-1:0] dot_current;
   logic [8*lmcfg_pkg::DOT_COUNT-1:0] dot_pwm;
   int errors = 0;
   int check_count = 0;
   int apply_count = 0;
   // Wired-AND data line with pull-up; the device only ever pulls low
   wire logic sda_line = ~(sda_pull | (sda_oe & ~sda_out));
   always #5 mclk = ~mclk;
   // Count apply pulses so a lost or doubled pulse shows up
   always @(posedge mclk) begin
      if (cfg_apply === 1'b1) begin
         apply_count++;
      end
   end
   lmcfg_host host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
   lmcfg_bank #(.CHIP_SEL(SEL)) DUT (
      .mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_enable(chip_enable), .range_51ma(range_51ma),
      .scan_topology(scan_topology), .short_threshold(short_threshold),
      .active_cfg(active_cfg), .cfg_apply(cfg_apply), .cfg_error(cfg_error),
      .led_enable(led_enable), .dot_current(dot_current), .dot_pwm(dot_pwm)
   );
   // Write n copies of one byte from address a on, auto-increment doing the rest
   task automatic reg_write(input logic [4:0] id, input logic [9:0] a, input logic [7:0] d,
                            input int n, output logic ok);
      logic [7:0] rx;
      logic r;
      host.start();
      host.xfer({id, a[9:8], 1'b0}, 1'b1, rx, r);
      ok = ~r;
      host.xfer(a[7:0], 1'b1, rx, r);
      repeat (n) host.xfer(d, 1'b1, rx, r);
      host.stop();
   endtask
   // Single-byte read ended by a controller NACK
   task automatic reg_read(input logic [9:0] a, output logic [7:0] d);
      logic [7:0] rx;
      logic r;
      host.start();
      host.xfer({OWN_ID, a[9:8], 1'b0}, 1'b1, rx, r);
      host.xfer(a[7:0], 1'b1, rx, r);
      host.start();
      host.xfer({OWN_ID, a[9:8], 1'b1}, 1'b1, rx, r);
      host.xfer(8'hff, 1'b1, d, r);
      host.stop();
   endtask
   // Counts and verdict, also reached from the watchdog
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watchdog sized well above the roughly 7.4k cycles the tests need
   initial begin
      repeat (80000) @(posedge mclk);
      errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      logic ok;
      logic [7:0] rd;
      int n0;
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      repeat (2) @(negedge mclk);
      `CHK("chip_enable", 1'b0, chip_enable)
      `CHK("active_cfg", lmcfg_pkg::CFG_RESET, active_cfg)
      `CHK("dot_pwm", 128'h0, dot_pwm)
      $display("test reset_defaults done");
      // Foreign chip address is refused, own address enables the device
      reg_write({lmcfg_pkg::CHIP_FAMILY, 2'h1}, 10'h000, 8'h01, 1, ok);
      `CHK("foreign_ack", 1'b0, ok)
      `CHK("chip_enable", 1'b0, chip_enable)
      reg_write(OWN_ID, 10'h000, 8'h01, 1, ok);
      `CHK("own_ack", 1'b1, ok)
      `CHK("chip_enable", 1'b1, chip_enable)
      $display("test enable done");
      // Staged writes stay invisible until the apply code arrives
      reg_write(OWN_ID, 10'h001, 8'h01, 1, ok);
      reg_write(OWN_ID, 10'h002, 8'h40, 1, ok);
      reg_write(OWN_ID, 10'h00d, 8'h0b, 1, ok);
      `CHK("range_staged", 1'b0, range_51ma)
      `CHK("topology_staged", 4'h0, scan_topology)
      reg_read(10'h002, rd);
      `CHK("read_002", 8'h40, rd)
      n0 = apply_count;
      reg_write(OWN_ID, 10'h010, 8'haa, 1, ok);
      `CHK("bad_cmd_pulses", n0, apply_count)
      `CHK("bad_cmd_range", 1'b0, range_51ma)
      reg_write(OWN_ID, 10'h010, lmcfg_pkg::CMD_APPLY, 1, ok);
      exp_cfg = '0;
      exp_cfg[8*lmcfg_pkg::CFG_IDX_RANGE +: 8] = 8'h01;
      exp_cfg[8*lmcfg_pkg::CFG_IDX_TOPO +: 8] = 8'h40;
      exp_cfg[8*lmcfg_pkg::CFG_IDX_SHORT +: 8] = 8'h0b;
      `CHK("apply_pulses", n0 + 1, apply_count)
      `CHK("active_cfg", exp_cfg, active_cfg)
      `CHK("range_51ma", 1'b1, range_51ma)
      `CHK("scan_topology", 4'h4, scan_topology)
      `CHK("short_threshold", 2'h3, short_threshold)
      reg_read(10'h010, rd);
      `CHK("read_010", 8'h00, rd)
      $display("test staged_apply done");
      // Error flag: clean after a good apply, set by a bad topology, cleared again
      reg_read(10'h300, rd);
      `CHK("status_ok", 8'h00, rd)
      reg_write(OWN_ID, 10'h002, 8'h80, 1, ok);
      reg_write(OWN_ID, 10'h010, lmcfg_pkg::CMD_APPLY, 1, ok);
      reg_read(10'h300, rd);
      `CHK("status_bad", 8'h01, rd)
      `CHK("cfg_error", 1'b1, cfg_error)
      reg_write(OWN_ID, 10'h002, 8'h40, 1, ok);
      reg_write(OWN_ID, 10'h010, lmcfg_pkg::CMD_APPLY, 1, ok);
      `CHK("cfg_error_clr", 1'b0, cfg_error)
      $display("test status done");
      // LED enables (upper four bits by broadcast), dot current and a PWM burst
      reg_write({lmcfg_pkg::BCAST_ID}, 10'h020, 8'hf0, 1, ok);
      `CHK("bcast_ack", 1'b1, ok)
      reg_write(OWN_ID, 10'h021, 8'hff, 1, ok);
      `CHK("led_enable", 12'hfff, led_enable)
      reg_read(10'h020, rd);
      `CHK("read_020", 8'hf0, rd)
      reg_write(OWN_ID, 10'h034, 8'hcc, 1, ok);
      reg_write(OWN_ID, 10'h035, 8'hff, 1, ok);
      `CHK("dot_current_4", 8'hcc, dot_current[8*4 +: 8])
      `CHK("dot_current_5", 8'hff, dot_current[8*5 +: 8])
      reg_write(OWN_ID, 10'h044, 8'hff, 12, ok);
      `CHK("dot_pwm", {{12{8'hff}}, 32'h0}, dot_pwm)
      reg_read(10'h0ff, rd);
      `CHK("read_unmapped", 8'h00, rd)
      $display("test leds done");
      wrap_up();
   end
endmodule
